/* File: ult_cable_model.sv */
// Far end of the cable: sends NRZI frames and decodes what the block drives.
// Assumes one bit per clock; line is SE0 and squelched outside frames.
`timescale 1ns/1ns
module ult_cable_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Block drivers
  input wire logic i_hs_tx_data,
  input wire logic i_hs_tx_oe,
  input wire logic i_fs_tx_data,
  input wire logic i_fs_tx_oe,
  // Block receivers
  output logic o_hs_rx_data,
  output logic o_fs_rx_data,
  output logic o_hs_squelch,
  output logic o_se_dp,
  output logic o_se_dm
);
  logic [1:0] q[$];
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] sh = 8'h00;
  logic tx_hs = 1'b0;
  logic prv = 1'b1;
  logic act = 1'b0;
  logic d;
  logic bt;
  int tx_cnt = 0;
  int n = 0;
  int ones = 0;
  // ==========
  // Frame builder: queue of {high speed, level}
  task automatic send(input logic [7:0] b, input logic m);
    logic lv;
    int k;
    lv = 1'b1;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) k++;
      else begin
        lv = ~lv;
        k = 0;
      end
      q.push_back({m, lv});
      if (k == 6) begin
        lv = ~lv;
        k = 0;
        q.push_back({m, lv});
      end
    end
  endtask
  // ==========
  // Idle data toggles so a stale level never looks valid
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {o_hs_squelch, o_se_dm, o_se_dp, o_fs_rx_data, o_hs_rx_data} <= 5'h10;
    end else if (q.size() > 0) begin
      o_hs_squelch <= ~q[0][1];
      {o_se_dm, o_se_dp} <= q[0][1] ? 2'b00 : {~q[0][0], q[0][0]};
      o_fs_rx_data <= q[0][0];
      o_hs_rx_data <= q[0][0];
      q.delete(0);
    end else begin
      o_hs_squelch <= 1'b1;
      {o_se_dm, o_se_dp} <= 2'b00;
      o_fs_rx_data <= ~o_fs_rx_data;
      o_hs_rx_data <= ~o_hs_rx_data;
    end
  end
  // ==========
  // Receive side: NRZI decode, drop stuffed bit, LSB first
  always @(posedge i_core_clk) begin
    if (i_hs_tx_oe || i_fs_tx_oe) begin
      d = i_hs_tx_oe ? i_hs_tx_data : i_fs_tx_data;
      bt = (d == prv);
      prv = d;
      // Enable leads the first bit by one cycle: that sample is the reference level
      if (!act) act = 1'b1;
      else if (ones == 6) ones = 0;
      else begin
        sh = {bt, sh[7:1]};
        ones = bt ? ones + 1 : 0;
        n++;
        if (n == 8) begin
          tx_byte = sh;
          tx_hs = i_hs_tx_oe;
          tx_cnt++;
          n = 0;
        end
      end
    end else begin
      prv = 1'b1;
      act = 1'b0;
      ones = 0;
      n = 0;
    end
  end
endmodule

/* File: ult_pkg.sv */
// Types shared by the termination decoder and the block top.
// No assumptions beyond a SystemVerilog elaborator.
package ult_pkg;

  // ==========================================
  // Termination enables toward the analog resistors
  typedef struct packed {
    logic pu_dp;
    logic pu_dm;
    logic pd_dp;
    logic pd_dm;
    logic hs_term;
  } ult_term_en_type;

  // ==========================================
  // Transceiver settings written by the link
  typedef struct packed {
    logic [1:0] xcvr_sel;
    logic term_sel;
    logic [1:0] operating_mode_field;
    logic dp_pd;
    logic dm_pd;
  } ult_cfg_type;

  typedef enum logic [1:0] {
    ULT_LINE_SE0 = 2'b00,
    ULT_LINE_J = 2'b01,
    ULT_LINE_K = 2'b10,
    ULT_LINE_SE1 = 2'b11
  } ult_line_type;

  typedef enum logic [1:0] {
    ULT_TX_IDLE = 2'b00,
    ULT_TX_SEND = 2'b01
  } ult_tx_state_type;

endpackage

/* File: ult_regs.svh */
// Register offsets, field positions, reset values and timing counts
// for the line termination and serial path block.
// Assumes a 32-bit APB slave with 8-bit byte addresses.
`ifndef ULT_REGS_SVH
`define ULT_REGS_SVH

// ==========================================
// Register offsets
`define ULT_CTRL_OFS 8'h00
`define ULT_STAT_OFS 8'h04
`define ULT_TXD_OFS 8'h08
`define ULT_RXD_OFS 8'h0c

// ==========================================
// Control register fields
`define ULT_XCVR_LSB 0
`define ULT_TERM_BIT 2
`define ULT_OPERATING_MODE_FIELD_LSB 3
`define ULT_DP_PD_BIT 5
`define ULT_DM_PD_BIT 6
`define ULT_BOOST_LSB 8
// Power-up setting: transceiver select 01b, both pull-down bits set
`define ULT_CTRL_RST 32'h0000_0061

// ==========================================
// Status and receive data fields
`define ULT_RXD_VALID_BIT 8
`define ULT_RXD_OVR_BIT 9

// ==========================================
// Serial path counts
`define ULT_STUFF_RUN 3'h6
`define ULT_BYTE_BITS 4'h8

`endif

/* File: ult_term_decode.sv */
// Termination decoder: settings to the five resistor enables.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module ult_term_decode
  import ult_pkg::*;
(
  // Settings
  input wire ult_cfg_type i_cfg,
  // Enables
  output ult_term_en_type o_en
);

  // ==========================================
  // Setting classes
  wire op_norm = (i_cfg.operating_mode_field == 2'b00);
  wire op_chirp = (i_cfg.operating_mode_field == 2'b10);
  wire x_hs = (i_cfg.xcvr_sel == 2'b00);
  wire x_fs = (i_cfg.xcvr_sel == 2'b01);
  wire x_ls = (i_cfg.xcvr_sel == 2'b10);
  wire tri_st = (i_cfg.operating_mode_field == 2'b01);
  wire host = i_cfg.dp_pd & i_cfg.dm_pd;
  wire periph = ~i_cfg.dp_pd;
  wire otg = ~i_cfg.dp_pd & i_cfg.dm_pd;

  // Host: high-speed path only for select 00b, term 0
  wire host_hs = x_hs & ~i_cfg.term_sel & (op_norm | op_chirp);
  wire host_fsls = i_cfg.term_sel & ((op_norm & ~x_hs) | (op_chirp & (x_fs | x_ls)));
  wire host_pwr = x_fs & ~i_cfg.term_sel & op_norm;
  wire host_ok = host & (host_hs | host_fsls | host_pwr);

  // Peripheral and OTG device share the high-speed and plus pull-up rows
  wire per_hs = x_hs & ~i_cfg.term_sel & (op_norm | op_chirp);
  wire per_dp = (x_hs & i_cfg.term_sel & op_chirp) | (x_fs & i_cfg.term_sel & (op_norm | op_chirp));
  // Low speed has no OTG device row, so the minus pull-down bit excludes it
  wire per_dm = x_ls & i_cfg.term_sel & (op_norm | op_chirp) & ~i_cfg.dm_pd;
  wire per_ok = periph & (per_hs | per_dp | per_dm);

  // Anything else, or tri-state, leaves all resistors off
  wire ok = ~tri_st & (host_ok | per_ok);

  assign o_en.pu_dp = ok & periph & per_dp;
  assign o_en.pu_dm = ok & periph & per_dm;
  assign o_en.pd_dp = ok & host;
  assign o_en.pd_dm = ok & (host | otg);
  assign o_en.hs_term = ok & ((host & host_hs) | (periph & per_hs));

endmodule

/* File: ult_top.sv */
// Line termination, receive and transmit serial path with APB registers.
// Assumes synchronous pin inputs and one bit per enabled clock cycle.
//
// Behaviour
// - Separate high-speed and full/low-speed receivers, muxed by mode into receive logic.
// - High-speed receive data is gated off while squelch reports noise.
// - Per-line single-ended receivers give the full-speed line state.
// - Transmit bytes are NRZI encoded, bit-stuffed and serialised onto the right driver.
// - A software boost field scales the high-speed driver amplitude.
// - Termination enables follow the current settings only, no calibration.
// - Decoder inputs: select, termination, mode, and both pull-down bits.
// - Two outputs enable the plus-line and minus-line pull-ups.
// - Two outputs separately enable the plus and minus pull-downs.
// - One output enables high-speed termination on both lines.
// - Host: both pull-downs; high-speed termination only for select 00b.
// - Peripheral: plus pull-up for chirp/full, minus for low, termination for high speed.
// - OTG device: peripheral enables plus the minus-line pull-down; low speed has no OTG row, so all five are off.
// - Undefined input combinations turn all five enables off.
// - No decode for an upstream hub port role.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "ult_regs.svh"
module ult_top
  import ult_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int BOOST_W = 3
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Receivers
  input wire logic i_hs_rx_data,
  input wire logic i_fs_rx_data,
  input wire logic i_hs_squelch,
  input wire logic i_se_dp,
  input wire logic i_se_dm,
  // Drivers
  output logic o_hs_tx_data,
  output logic o_hs_tx_oe,
  output logic o_fs_tx_data,
  output logic o_fs_tx_oe,
  output logic [BOOST_W-1:0] o_tx_boost,
  // Termination resistors
  output ult_term_en_type o_term_en
);

  // ==========================================
  // Elaboration checks
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk_addr
    $error("ult_top: ADDR_W must be 4..32");
  end
  if (BOOST_W < 1 || BOOST_W > 8) begin : g_chk_boost
    $error("ult_top: BOOST_W must be 1..8");
  end

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_is = (a == ADDR_W'(ofs));
  endfunction

  // NRZI: a zero toggles the line, a one keeps it
  function automatic logic nrzi_next(input logic line, input logic bit_v);
    nrzi_next = bit_v ? line : ~line;
  endfunction

  // ==========================================
  // Register state
  logic [31:0] ctrl_r;
  logic [7:0] hold_r;
  logic hold_vld_r;
  logic [7:0] rx_byte_r;
  logic rx_vld_r;
  logic rx_ovr_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  ult_cfg_type cfg;
  assign cfg.xcvr_sel = ctrl_r[`ULT_XCVR_LSB +: 2];
  assign cfg.term_sel = ctrl_r[`ULT_TERM_BIT];
  assign cfg.operating_mode_field = ctrl_r[`ULT_OPERATING_MODE_FIELD_LSB +: 2];
  assign cfg.dp_pd = ctrl_r[`ULT_DP_PD_BIT];
  assign cfg.dm_pd = ctrl_r[`ULT_DM_PD_BIT];

  wire hs_mode = (cfg.xcvr_sel == 2'b00);
  wire drv_off = (cfg.operating_mode_field == 2'b01);

  // ==========================================
  // APB decode
  wire sel_ctrl = addr_is(i_paddr, `ULT_CTRL_OFS);
  wire sel_stat = addr_is(i_paddr, `ULT_STAT_OFS);
  wire sel_txd = addr_is(i_paddr, `ULT_TXD_OFS);
  wire sel_rxd = addr_is(i_paddr, `ULT_RXD_OFS);
  wire mapped = sel_ctrl | sel_stat | sel_txd | sel_rxd;
  wire access = i_psel & i_penable;
  // Completion edge: the one at which pready is seen high
  wire done = access & pready_r;
  // A data write waits while the holding byte is still occupied
  wire can_ans = ~(i_pwrite & sel_txd & hold_vld_r);
  wire raise = access & ~pready_r & can_ans;
  wire wr_ctrl = done & i_pwrite & sel_ctrl;
  wire wr_txd = done & i_pwrite & sel_txd;
  wire rd_rxd = done & ~i_pwrite & sel_rxd;

  // ==========================================
  // Line state and receive path
  logic [1:0] line_raw;
  assign line_raw = {i_se_dm, i_se_dp};
  ult_line_type line_st;
  assign line_st = ult_line_type'(line_raw);

  wire rx_bit_in = hs_mode ? i_hs_rx_data : i_fs_rx_data;
  // Noise below squelch never enters the deserialiser
  wire rx_act = hs_mode ? ~i_hs_squelch : (line_st == ULT_LINE_J || line_st == ULT_LINE_K);

  logic rx_prev_r;
  logic [2:0] rx_ones_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_cnt_r;

  wire rx_dec = (rx_bit_in == rx_prev_r);
  wire rx_drop = (rx_ones_r == `ULT_STUFF_RUN);
  wire rx_take = rx_act & ~rx_drop;
  wire rx_full = rx_take & (rx_cnt_r == 3'h7);
  wire [7:0] rx_sh_nxt = {rx_dec, rx_sh_r[7:1]};

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_prev_r <= 1'b1;
      rx_ones_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
    end else if (i_clk_en) begin
      if (!rx_act) begin
        rx_prev_r <= 1'b1;
        rx_ones_r <= 3'h0;
        rx_cnt_r <= 3'h0;
      end else begin
        rx_prev_r <= rx_bit_in;
        if (rx_drop) begin
          rx_ones_r <= 3'h0;
        end else begin
          rx_ones_r <= rx_dec ? rx_ones_r + 3'h1 : 3'h0;
          rx_sh_r <= rx_sh_nxt;
          rx_cnt_r <= rx_cnt_r + 3'h1;
        end
      end
    end
  end

  // A fresh byte wins over a read that clears the previous one
  logic rx_vld_nxt;
  logic rx_ovr_nxt;
  assign rx_vld_nxt = rx_full | (rx_vld_r & ~rd_rxd);
  assign rx_ovr_nxt = (rx_full & rx_vld_r & ~rd_rxd) | (rx_ovr_r & ~rd_rxd);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_byte_r <= 8'h00;
      rx_vld_r <= 1'b0;
      rx_ovr_r <= 1'b0;
    end else if (i_clk_en) begin
      if (rx_full) begin
        rx_byte_r <= rx_sh_nxt;
      end
      rx_vld_r <= rx_vld_nxt;
      rx_ovr_r <= rx_ovr_nxt;
    end
  end

  // ==========================================
  // Transmit path
  ult_tx_state_type tx_st_r;
  ult_tx_state_type tx_st_nxt;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic [2:0] tx_ones_r;
  logic tx_line_r;

  wire tx_stuff = (tx_ones_r == `ULT_STUFF_RUN);
  wire tx_data_step = (tx_st_r == ULT_TX_SEND) & ~tx_stuff & (tx_bits_r != 4'h0);
  // Next byte is picked up on the last bit so the stream has no gap
  wire tx_load = hold_vld_r & ((tx_st_r == ULT_TX_IDLE) | (tx_data_step & (tx_bits_r == 4'h1)));
  wire tx_end = (tx_st_r == ULT_TX_SEND) & ~tx_stuff & (tx_bits_r == 4'h0);

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      ULT_TX_IDLE: begin
        if (tx_load) begin
          tx_st_nxt = ULT_TX_SEND;
        end
      end
      ULT_TX_SEND: begin
        if (tx_end) begin
          tx_st_nxt = ULT_TX_IDLE;
        end
      end
      default: tx_st_nxt = ULT_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_st_r <= ULT_TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_bits_r <= 4'h0;
      tx_ones_r <= 3'h0;
      tx_line_r <= 1'b1;
    end else if (i_clk_en) begin
      tx_st_r <= tx_st_nxt;
      if (tx_st_r == ULT_TX_SEND && tx_stuff) begin
        tx_line_r <= nrzi_next(tx_line_r, 1'b0);
        tx_ones_r <= 3'h0;
      end else if (tx_data_step) begin
        tx_line_r <= nrzi_next(tx_line_r, tx_sh_r[0]);
        tx_ones_r <= tx_sh_r[0] ? tx_ones_r + 3'h1 : 3'h0;
        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
        tx_bits_r <= tx_bits_r - 4'h1;
      end
      if (tx_load) begin
        tx_sh_r <= hold_r;
        tx_bits_r <= `ULT_BYTE_BITS;
      end
      if (tx_end) begin
        tx_ones_r <= 3'h0;
      end
    end
  end

  // ==========================================
  // Drivers, boost and termination outputs
  ult_term_en_type term_dec;

  ult_term_decode u_term (
    .i_cfg(cfg),
    .o_en(term_dec)
  );

  wire tx_on = (tx_st_nxt == ULT_TX_SEND) & ~drv_off;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hs_tx_oe <= 1'b0;
      o_fs_tx_oe <= 1'b0;
      o_tx_boost <= '0;
      o_term_en <= '0;
    end else if (i_clk_en) begin
      o_hs_tx_oe <= tx_on & hs_mode;
      o_fs_tx_oe <= tx_on & ~hs_mode;
      o_tx_boost <= ctrl_r[`ULT_BOOST_LSB +: BOOST_W];
      // Enables follow the settings directly; nothing to trim
      o_term_en <= term_dec;
    end
  end

  // The line level flop feeds both drivers; only the enables differ
  assign o_hs_tx_data = tx_line_r;
  assign o_fs_tx_data = tx_line_r;

  // ==========================================
  // Register writes and holding byte
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `ULT_CTRL_RST;
      hold_r <= 8'h00;
      hold_vld_r <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= i_pwdata;
      end
      if (wr_txd) begin
        hold_r <= i_pwdata[7:0];
      end
      hold_vld_r <= wr_txd | (hold_vld_r & ~tx_load);
    end
  end

  // ==========================================
  // Read data and APB answer
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  assign stat_word = {22'h0, hold_vld_r, tx_st_r == ULT_TX_SEND, o_term_en, i_hs_squelch, line_raw};
  assign rd_word = sel_ctrl ? ctrl_r :
                   sel_stat ? stat_word :
                   sel_txd ? {24'h0, hold_r} :
                   sel_rxd ? {22'h0, rx_ovr_r, rx_vld_r, rx_byte_r} : 32'h0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else if (i_clk_en) begin
      pready_r <= raise;
      if (raise) begin
        pslverr_r <= ~mapped;
        prdata_r <= i_pwrite ? 32'h0 : rd_word;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_prdata = prdata_r;

endmodule

/* File: ult_top_assertions.sv */
// Concurrent checks on the termination decode and driver ports of ult_top.
// Assumes the APB access phase completes when pready is sampled high.
`timescale 1ns/1ns
`include "ult_regs.svh"
module ult_top_assertions
  import ult_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int BOOST_W = 3
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  // Line side
  input wire logic o_hs_tx_oe,
  input wire logic o_fs_tx_oe,
  input wire logic [BOOST_W-1:0] o_tx_boost,
  input wire ult_term_en_type o_term_en
);
  // ==========
  // Control write seen at its completion edge
  wire logic wr;
  wire logic [6:0] cfg;
  wire logic [BOOST_W-1:0] bst;
  assign wr = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == ADDR_W'(`ULT_CTRL_OFS));
  assign cfg = i_pwdata[6:0];
  assign bst = i_pwdata[`ULT_BOOST_LSB +: BOOST_W];
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========
  // Decode results two edges after the write
  property p_off;
    (wr && cfg[3]) ##1 i_clk_en |=> o_term_en == 5'h00;
  endproperty
  a_off: assert property (p_off) else $error("enables left on for tri-state or undefined mode");
  property p_host;
    (wr && cfg == 7'h60) ##1 i_clk_en |=> o_term_en == 5'h07;
  endproperty
  a_host: assert property (p_host) else $error("host high speed decode wrong");
  property p_otg;
    (wr && cfg == 7'h45) ##1 i_clk_en |=> o_term_en == 5'h12;
  endproperty
  a_otg: assert property (p_otg) else $error("otg full speed decode wrong");
  property p_low;
    (wr && cfg == 7'h06) ##1 i_clk_en |=> o_term_en == 5'h08;
  endproperty
  a_low: assert property (p_low) else $error("peripheral low speed decode wrong");
  property p_boost;
    wr ##1 i_clk_en |=> o_tx_boost == $past(bst, 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost not copied from control");
  property p_powerup;
    $rose(i_rstn) && i_clk_en |=> o_term_en == 5'h06;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up decode wrong");
  // ==========
  // Combinations that no valid setting produces
  property p_pu;
    !(o_term_en.pu_dp && o_term_en.pu_dm);
  endproperty
  a_pu: assert property (p_pu) else $error("both pull-ups on");
  property p_hs;
    o_term_en.hs_term |-> !o_term_en.pu_dp && !o_term_en.pu_dm;
  endproperty
  a_hs: assert property (p_hs) else $error("termination with a pull-up");
  property p_pd;
    o_term_en.pd_dp |-> o_term_en.pd_dm && !o_term_en.pu_dp;
  endproperty
  a_pd: assert property (p_pd) else $error("plus pull-down without minus");
  property p_drv;
    !(o_hs_tx_oe && o_fs_tx_oe);
  endproperty
  a_drv: assert property (p_drv) else $error("both drivers enabled");
endmodule
bind ult_top ult_top_assertions #(.ADDR_W(ADDR_W), .BOOST_W(BOOST_W)) i_chk (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_hs_tx_oe(o_hs_tx_oe), .o_fs_tx_oe(o_fs_tx_oe),
  .o_tx_boost(o_tx_boost), .o_term_en(o_term_en));

/* File: ult_top_test.sv */
// Self-checking bench for ult_top: decode table, boost, serial paths.
// Assumes the cable model on the line side and an APB master here.
`timescale 1ns/1ns
`include "ult_regs.svh"
module ult_top_test
  import ult_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hs_tx, hs_oe, fs_tx, fs_oe, hs_rx, fs_rx, sq, se_dp, se_dm;
  logic [2:0] boost;
  ult_term_en_type term;
  logic [31:0] seed = 32'h43f4cf10;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  ult_top i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_hs_rx_data(hs_rx), .i_fs_rx_data(fs_rx), .i_hs_squelch(sq),
    .i_se_dp(se_dp), .i_se_dm(se_dm), .o_hs_tx_data(hs_tx), .o_hs_tx_oe(hs_oe),
    .o_fs_tx_data(fs_tx), .o_fs_tx_oe(fs_oe), .o_tx_boost(boost), .o_term_en(term));
  ult_cable_model i_cable (.i_core_clk(clk), .i_rstn(rstn), .i_hs_tx_data(hs_tx), .i_hs_tx_oe(hs_oe),
    .i_fs_tx_data(fs_tx), .i_fs_tx_oe(fs_oe), .o_hs_rx_data(hs_rx), .o_fs_rx_data(fs_rx),
    .o_hs_squelch(sq), .o_se_dp(se_dp), .o_se_dm(se_dm));
  // ==========
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function logic [31:0] rnd;
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction
  // Expected enables {pu_dp, pu_dm, pd_dp, pd_dm, hs_term}
  function automatic logic [4:0] exp_term(input logic [6:0] c);
    logic [1:0] x;
    logic hs, otg;
    x = c[1:0];
    otg = c[6:5] == 2'b10;
    hs = x == 2'b00 && !c[2];
    if (c[3]) return 5'h00;
    if (c[6:5] == 2'b11) return hs ? 5'h07 : ((c[2] && x != 2'b00 && !(x == 2'b11 && c[4]))
      || (c[2:0] == 3'b001 && !c[4])) ? 5'h06 : 5'h00;
    if (c[5]) return 5'h00;
    if (hs) return otg ? 5'h03 : 5'h01;
    if (c[2] && (x == 2'b01 || (x == 2'b00 && c[4]))) return otg ? 5'h12 : 5'h10;
    if (c[2] && x == 2'b10 && !otg) return 5'h08;
    return 5'h00;
  endfunction
  // One transfer; holds the request until pready, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // ==========
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] b;
    logic [2:0] bo;
    int n0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check(term, 5'h06);
    apb(1'b0, `ULT_CTRL_OFS, 32'h0, r, e);
    check(r, `ULT_CTRL_RST);
    apb(1'b0, 8'h10, 32'h0, r, e);
    check({e, r[30:0]}, 32'h80000000);
    for (int i = 0; i < 128; i++) begin
      bo = 3'(rnd());
      apb(1'b1, `ULT_CTRL_OFS, {21'h0, bo, 1'b0, 7'(i)}, r, e);
      @(posedge clk);
      check(term, exp_term(7'(i)));
      check(boost, bo);
      apb(1'b0, `ULT_STAT_OFS, 32'h0, r, e);
      check(r[7:3], exp_term(7'(i)));
    end
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        b = (k == 0) ? 8'hff : 8'(rnd());
        apb(1'b1, `ULT_CTRL_OFS, m ? 32'h0 : 32'h5, r, e);
        n0 = i_cable.tx_cnt;
        apb(1'b1, `ULT_TXD_OFS, {24'h0, b}, r, e);
        for (int t = 0; t < 100 && i_cable.tx_cnt == n0; t++) @(posedge clk);
        check(i_cable.tx_byte, b);
        check(i_cable.tx_hs, m);
        i_cable.send(b, m[0]);
        repeat (16) @(posedge clk);
        apb(1'b0, `ULT_RXD_OFS, 32'h0, r, e);
        check(r[9:0], {2'b01, b});
        apb(1'b0, `ULT_RXD_OFS, 32'h0, r, e);
        check(r[8], 1'b0);
      end
    end
    stop_test();
  end
endmodule
